// ---- hw/tvt_timing_top.sv ----
`timescale 1ns/1ps
module tvt_timing_top (
  input  wire logic           mclk_in,
  input  wire logic           rst_n_in,
  input  wire logic           sync_clear_in,
  input  wire logic           refresh_50hz_in,
  input  wire logic           test_observe_in,
  input  wire logic           cmd_valid_in,
  output logic                dot_tick_out,
  output logic                dot_cycle_last_stage_n_out,
  output logic                chargen_fetch_out,
  output logic                serializer_preset_out,
  output logic [6:0]          chargen_col_out,
  output logic [2:0]          chargen_line_out,
  output logic                char_count_bit0_out,
  output logic                char_count_bit6_out,
  output logic                char_retrace_weight80_out,
  output logic                char_at_80_flag_n_out,
  output logic                line_counter_clk_n_out,
  output logic                video_line_out,
  output logic                video_active_out,
  output logic [5:0]          row_cnt_out,
  output logic                frame_end_out,
  output logic                refresh_50hz_out,
  output logic                cmd_accept_out,
  output tvt_pkg::tvt_counts_s obs_counts_out,
  output logic                obs_oe_n_out
);

  typedef struct packed {
    logic [tvt_pkg::NCO_W-1:0] nco;
    logic                      tick;
    logic [2:0]                strap_sync;
    logic                      sel50;
    logic [2:0]                obs_sync;
    logic                      obs_en;
    logic [7:0]                char_cnt;
    logic                      at80_n;
    logic                      at80_pulse;
    logic                      line_clk_n;
    logic [3:0]                line_cnt;
    logic                      row_adv;
    logic                      fetch;
    logic                      preset;
    logic [6:0]                col;
    logic [2:0]                glyph_line;
  } tvt_top_state_s;

  localparam tvt_top_state_s ST_RST = '{
    nco:        tvt_pkg::NCO_RST,
    tick:       1'b0,
    strap_sync: 3'h0,
    sel50:      1'b0,
    obs_sync:   3'h0,
    obs_en:     1'b0,
    char_cnt:   tvt_pkg::CHAR_RST,
    at80_n:     1'b1,
    at80_pulse: 1'b0,
    line_clk_n: 1'b1,
    line_cnt:   tvt_pkg::LINE_RST,
    row_adv:    1'b0,
    fetch:      1'b0,
    preset:     1'b0,
    col:        7'h00,
    glyph_line: 3'h0
  };

  tvt_top_state_s st_q;
  tvt_top_state_s st_d;

  logic [3:0] dot_cnt;
  logic       cell_end;
  logic       dot_last_n;
  logic [5:0] row_cnt;
  logic       frame_end;
  logic [tvt_pkg::NCO_W:0] nco_sum;

  // next character count, including the 79 -> 240 jump
  function automatic logic [7:0] tvt_char_next(input logic [7:0] cnt);
    logic [7:0] nxt;
    nxt = cnt + 8'h01;
    if (cnt == tvt_pkg::CHAR_VIS_LAST) begin
      nxt = tvt_pkg::CHAR_RETRACE_1ST;
    end else if (cnt == tvt_pkg::CHAR_LAST) begin
      nxt = tvt_pkg::CHAR_RST;
    end
    return nxt;
  endfunction : tvt_char_next

  // three-stage pin capture: value moves only when stages 2 and 3 agree
  function automatic logic tvt_pin_filter(input logic [2:0] sync,
                                          input logic       cur);
    logic res;
    res = cur;
    if (sync[1] == sync[2]) begin
      res = sync[2];
    end
    return res;
  endfunction : tvt_pin_filter

  // is this raster line one that carries glyph video
  function automatic logic tvt_is_video_line(input logic [3:0] line);
    logic res;
    res = (line >= tvt_pkg::LINE_FIRST) &&
          (line <  tvt_pkg::LINE_LAST);
    return res;
  endfunction : tvt_is_video_line

  // fractional tick generator standing in for the dot oscillator;
  // jitter of one system clock is traded for a single clock domain
  assign nco_sum = {1'b0, st_q.nco} + {1'b0, tvt_pkg::NCO_INC};

  tvt_dot_counter u_dot (
    .mclk_in                    (mclk_in),
    .rst_n_in                   (rst_n_in),
    .tick_in                    (st_q.tick),
    .clear_in                   (sync_clear_in),
    .dot_cnt_out                (dot_cnt),
    .cell_end_out               (cell_end),
    .dot_cycle_last_stage_n_out (dot_last_n)
  );

  tvt_row_counter u_row (
    .mclk_in       (mclk_in),
    .rst_n_in      (rst_n_in),
    .adv_in        (st_q.row_adv),
    .clear_in      (sync_clear_in),
    .sel_50hz_in   (st_q.sel50),
    .row_cnt_out   (row_cnt),
    .frame_end_out (frame_end)
  );

  always_comb begin
    st_d = st_q;

    // master tick at the oscillator rate
    st_d.nco  = nco_sum[tvt_pkg::NCO_W-1:0];
    st_d.tick = nco_sum[tvt_pkg::NCO_W];

    // pins: first stage feeds only the second
    st_d.strap_sync = {st_q.strap_sync[1:0], refresh_50hz_in};
    st_d.sel50      = tvt_pin_filter(st_q.strap_sync, st_q.sel50);
    st_d.obs_sync   = {st_q.obs_sync[1:0], test_observe_in};
    st_d.obs_en     = tvt_pin_filter(st_q.obs_sync, st_q.obs_en);

    // pulses default inactive: low, except line_clk_n high
    st_d.at80_pulse = 1'b0;
    st_d.line_clk_n = 1'b1;
    st_d.row_adv    = 1'b0;
    st_d.fetch      = 1'b0;
    st_d.preset     = 1'b0;

    // glyph fetch and serializer preset steered by dot state
    if (st_q.tick && !sync_clear_in) begin
      if (dot_cnt == tvt_pkg::DOT_FETCH) begin
        st_d.fetch      = 1'b1;
        st_d.col        = st_q.char_cnt[6:0];
        st_d.glyph_line = 3'(st_q.line_cnt - tvt_pkg::LINE_FIRST);
      end
      if (dot_cnt == tvt_pkg::DOT_PRESET) begin
        st_d.preset = 1'b1;
      end
    end

    if (sync_clear_in) begin
      st_d.char_cnt = tvt_pkg::CHAR_RST;
      st_d.line_cnt = tvt_pkg::LINE_RST;
      st_d.at80_n   = 1'b1;
    end else if (cell_end) begin
      // advance once per completed dot cycle
      st_d.char_cnt = tvt_char_next(st_q.char_cnt);

      // decode of the count about to be entered, held in a flop
      st_d.at80_n = (tvt_char_next(st_q.char_cnt) !=
                     tvt_pkg::CHAR_AT_80);
      st_d.at80_pulse = (tvt_char_next(st_q.char_cnt) ==
                         tvt_pkg::CHAR_AT_80);

      if (st_q.char_cnt == tvt_pkg::CHAR_LAST) begin
        // end of raster line clocks the line counter
        st_d.line_clk_n = 1'b0;
        if (st_q.line_cnt == tvt_pkg::LINE_LAST) begin
          st_d.line_cnt = tvt_pkg::LINE_RST;
          st_d.row_adv  = 1'b1;
        end else begin
          st_d.line_cnt = st_q.line_cnt + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign dot_tick_out               = st_q.tick;
  assign dot_cycle_last_stage_n_out = dot_last_n;
  assign chargen_fetch_out          = st_q.fetch;
  assign serializer_preset_out      = st_q.preset;
  assign chargen_col_out            = st_q.col;
  assign chargen_line_out           = st_q.glyph_line;

  // raw stages: low seven binary, the top one standing for 80
  assign char_count_bit0_out        = st_q.char_cnt[0];
  assign char_count_bit6_out        = st_q.char_cnt[6];
  assign char_retrace_weight80_out  =
    st_q.char_cnt[tvt_pkg::CHAR_W80_BIT];
  assign char_at_80_flag_n_out      = st_q.at80_n;
  assign line_counter_clk_n_out     = st_q.line_clk_n;

  assign video_line_out   = tvt_is_video_line(st_q.line_cnt);
  assign video_active_out = ~st_q.char_cnt[tvt_pkg::CHAR_W80_BIT] &
                            tvt_is_video_line(st_q.line_cnt);

  assign row_cnt_out      = row_cnt;
  assign frame_end_out    = frame_end;
  assign refresh_50hz_out = st_q.sel50;

  // host side only gets through in the first clock of count 80
  assign cmd_accept_out = cmd_valid_in & st_q.at80_pulse;

  // observation port is read only; its enable feeds nothing else
  assign obs_counts_out = '{dot_cnt:  dot_cnt,
                            char_cnt: st_q.char_cnt,
                            line_cnt: st_q.line_cnt,
                            row_cnt:  row_cnt};
  assign obs_oe_n_out   = ~st_q.obs_en;

endmodule : tvt_timing_top

// ---- hw/tvt_pkg.sv ----
package tvt_pkg;

  // master dot oscillator and the system clock that carries it
  localparam longint MASTER_HZ = 64'd10886400;
  localparam longint CLK_HZ    = 64'd25000000;
  localparam int     NCO_W     = 24;
  localparam logic [NCO_W-1:0] NCO_INC =
    NCO_W'((MASTER_HZ << NCO_W) / CLK_HZ);
  localparam logic [NCO_W-1:0] NCO_RST = 24'h000000;

  // dot counter: seven states per character cell
  localparam logic [3:0] DOT_LOAD      = 4'hA;
  localparam logic [3:0] DOT_OVERFLOW  = 4'hF;
  localparam logic [3:0] DOT_LAST      = 4'h0;
  localparam logic [3:0] DOT_FETCH     = 4'hA;
  localparam logic [3:0] DOT_PRESET    = 4'hF;
  localparam int         DOT_STAGE_MSB = 3;

  // character counter: 0..79 then 240..255
  localparam logic [7:0] CHAR_RST         = 8'h00;
  localparam logic [7:0] CHAR_VIS_LAST    = 8'h4F;
  localparam logic [7:0] CHAR_RETRACE_1ST = 8'hF0;
  localparam logic [7:0] CHAR_LAST        = 8'hFF;
  localparam logic [7:0] CHAR_AT_80       = 8'hF0;
  localparam int         CHAR_W80_BIT     = 7;

  // line counter: divide by nine
  localparam logic [3:0] LINE_RST   = 4'h0;
  localparam logic [3:0] LINE_FIRST = 4'h1;
  localparam logic [3:0] LINE_LAST  = 4'h8;

  // row counter: 30 rows at 60 Hz, 36 rows at 50 Hz
  localparam logic [5:0] ROW_RST     = 6'h00;
  localparam logic [5:0] ROW_LAST_60 = 6'h1D;
  localparam logic [5:0] ROW_LAST_50 = 6'h23;

  typedef struct packed {
    logic [3:0] dot_cnt;
    logic [7:0] char_cnt;
    logic [3:0] line_cnt;
    logic [5:0] row_cnt;
  } tvt_counts_s;

endpackage : tvt_pkg

// ---- hw/tvt_dot_counter.sv ----
`timescale 1ns/1ps
module tvt_dot_counter (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       tick_in,
  input  wire logic       clear_in,
  output logic [3:0]      dot_cnt_out,
  output logic            cell_end_out,
  output logic            dot_cycle_last_stage_n_out
);

  typedef struct packed {
    logic [3:0] dot;
    logic       cell_end;
  } tvt_dot_state_s;

  tvt_dot_state_s st_q;
  tvt_dot_state_s st_d;

  always_comb begin
    st_d          = st_q;
    st_d.cell_end = 1'b0;
    if (clear_in) begin
      st_d.dot = tvt_pkg::DOT_LOAD;
    end else if (tick_in) begin
      if (st_q.dot == tvt_pkg::DOT_LAST) begin
        st_d.dot      = tvt_pkg::DOT_LOAD;
        st_d.cell_end = 1'b1;
      end else if (st_q.dot == tvt_pkg::DOT_OVERFLOW) begin
        st_d.dot = tvt_pkg::DOT_LAST;
      end else begin
        st_d.dot = st_q.dot + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '{dot: tvt_pkg::DOT_LOAD, cell_end: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign dot_cnt_out  = st_q.dot;
  assign cell_end_out = st_q.cell_end;
  // top stage low only in state 0: one state in seven
  assign dot_cycle_last_stage_n_out =
    st_q.dot[tvt_pkg::DOT_STAGE_MSB];

endmodule : tvt_dot_counter

// ---- hw/tvt_row_counter.sv ----
`timescale 1ns/1ps
module tvt_row_counter (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       adv_in,
  input  wire logic       clear_in,
  input  wire logic       sel_50hz_in,
  output logic [5:0]      row_cnt_out,
  output logic            frame_end_out
);

  typedef struct packed {
    logic [5:0] row;
    logic       frame_end;
  } tvt_row_state_s;

  tvt_row_state_s st_q;
  tvt_row_state_s st_d;
  logic [5:0]     row_last;

  // strap picks the terminal count
  assign row_last = sel_50hz_in ? tvt_pkg::ROW_LAST_50
                                : tvt_pkg::ROW_LAST_60;

  always_comb begin
    st_d           = st_q;
    st_d.frame_end = 1'b0;
    if (clear_in) begin
      st_d.row = tvt_pkg::ROW_RST;
    end else if (adv_in) begin
      // >= guards a strap change that lands above the new maximum
      if (st_q.row >= row_last) begin
        st_d.row       = tvt_pkg::ROW_RST;
        st_d.frame_end = 1'b1;
      end else begin
        st_d.row = st_q.row + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '{row: tvt_pkg::ROW_RST, frame_end: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign row_cnt_out   = st_q.row;
  assign frame_end_out = st_q.frame_end;

endmodule : tvt_row_counter

// ---- testbench/tvt_timing_top_assertions.sv ----
`timescale 1ns/1ps
module tvt_timing_chk (
  input wire logic                 mclk_in,
  input wire logic                 rst_n_in,
  input wire logic                 sync_clear_in,
  input wire logic                 cmd_valid_in,
  input wire logic                 dot_cycle_last_stage_n_out,
  input wire logic                 char_at_80_flag_n_out,
  input wire logic                 video_line_out,
  input wire logic                 cmd_accept_out,
  input wire logic                 refresh_50hz_out,
  input wire logic [5:0]           row_cnt_out,
  input wire logic                 frame_end_out,
  input wire logic                 chargen_fetch_out,
  input wire logic [6:0]           chargen_col_out,
  input wire logic [2:0]           chargen_line_out,
  input wire tvt_pkg::tvt_counts_s obs_counts_out
);
  tvt_pkg::tvt_counts_s c;
  tvt_pkg::tvt_counts_s p;
  logic                 clr_q;
  assign c = obs_counts_out;
  // previous counts; a clear jumps them, so those edges are skipped
  always_ff @(posedge mclk_in) begin
    p     <= obs_counts_out;
    clr_q <= sync_clear_in;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in || sync_clear_in || clr_q);
  property p_dot_step;
    c.dot_cnt != p.dot_cnt |-> c.dot_cnt == ((p.dot_cnt == 4'hF) ? 4'h0 :
      (p.dot_cnt == 4'h0) ? 4'hA : p.dot_cnt + 4'h1);
  endproperty
  a_dot_step: assert property (p_dot_step) else $error("dot step");
  property p_last_stage;
    $fell(dot_cycle_last_stage_n_out) |-> c.dot_cnt == 4'h0;
  endproperty
  a_last_stage: assert property (p_last_stage) else $error("last low");
  // the column is latched between counter steps, so it must match
  property p_fetch_col;
    chargen_fetch_out |-> chargen_col_out == c.char_cnt[6:0];
  endproperty
  a_fetch_col: assert property (p_fetch_col) else $error("fetch col");
  property p_fetch_line;
    chargen_fetch_out && video_line_out |->
      chargen_line_out == c.line_cnt[2:0] - 3'h1;
  endproperty
  a_fetch_line: assert property (p_fetch_line) else $error("glyph line");
  property p_frame_end;
    frame_end_out |-> row_cnt_out == 6'h00 && $past(row_cnt_out) != 6'h00;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame end");
  property p_char_step;
    c.char_cnt != p.char_cnt |-> c.char_cnt ==
      ((p.char_cnt == 8'h4F) ? 8'hF0 : p.char_cnt + 8'h1);
  endproperty
  a_char_step: assert property (p_char_step) else $error("char step");
  property p_char_dot;
    c.char_cnt != p.char_cnt |-> c.dot_cnt == 4'hA &&
      $past(c.dot_cnt, 2) == 4'h0;
  endproperty
  a_char_dot: assert property (p_char_dot) else $error("char clock");
  property p_flag;
    !char_at_80_flag_n_out |-> c.char_cnt == 8'hF0 || p.char_cnt == 8'hF0;
  endproperty
  a_flag: assert property (p_flag) else $error("count 80 flag");
  property p_acc;
    cmd_accept_out |-> cmd_valid_in && !char_at_80_flag_n_out;
  endproperty
  a_acc: assert property (p_acc) else $error("accept moment");
  property p_acc_once;
    cmd_accept_out |=> !cmd_accept_out [*8];
  endproperty
  a_acc_once: assert property (p_acc_once) else $error("accept twice");
  property p_line;
    c.line_cnt != p.line_cnt |-> c.char_cnt == 8'h00 && c.line_cnt ==
      ((p.line_cnt == 4'h8) ? 4'h0 : p.line_cnt + 4'h1);
  endproperty
  a_line: assert property (p_line) else $error("line step");
  property p_video;
    video_line_out == (c.line_cnt inside {[4'h1:4'h7]});
  endproperty
  a_video: assert property (p_video) else $error("video line");
  property p_row_clk;
    row_cnt_out != $past(row_cnt_out) |-> c.line_cnt == 4'h0 &&
      c.char_cnt == 8'h00;
  endproperty
  a_row_clk: assert property (p_row_clk) else $error("row clock");
  property p_row_max;
    row_cnt_out <= (refresh_50hz_out ? 6'h23 : 6'h1D);
  endproperty
  a_row_max: assert property (p_row_max) else $error("row max");
  c_acc: cover property (cmd_accept_out);
  c_row: cover property (row_cnt_out != $past(row_cnt_out));
  c_line: cover property (c.line_cnt == 4'h8 ##1 c.line_cnt == 4'h0);
endmodule : tvt_timing_chk

bind tvt_timing_top tvt_timing_chk u_chk (.*);

// ---- testbench/tvt_crt_model.sv ----
`timescale 1ns/1ps
module tvt_crt_model (
  input  wire logic       mclk_in,
  input  wire logic       fetch_in,
  input  wire logic       preset_in,
  input  wire logic       active_in,
  input  wire logic       hsync_n_in,
  output logic [7:0]      fetch_cnt_out,
  output logic [7:0]      preset_cnt_out,
  output logic [7:0]      vis_cnt_out
);
  logic [7:0] f_q = 8'h00;
  logic [7:0] p_q = 8'h00;
  logic [7:0] v_q = 8'h00;
  // a strobe in the sync cycle belongs to the new line
  always_ff @(posedge mclk_in) begin
    if (!hsync_n_in) begin
      fetch_cnt_out  <= f_q;
      preset_cnt_out <= p_q;
      vis_cnt_out    <= v_q;
      f_q <= {7'h0, fetch_in};
      p_q <= {7'h0, preset_in};
      v_q <= {7'h0, fetch_in & active_in};
    end else begin
      f_q <= f_q + {7'h0, fetch_in};
      p_q <= p_q + {7'h0, preset_in};
      v_q <= v_q + {7'h0, fetch_in & active_in};
    end
  end
endmodule : tvt_crt_model

// ---- testbench/tvt_timing_top_tb.sv ----
`timescale 1ns/1ps
module tvt_timing_top_tb;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sync_clear_in = 1'b0;
  logic refresh_50hz_in = 1'b0;
  logic test_observe_in = 1'b1;
  logic cmd_valid_in = 1'b0;
  logic last_n, fetch, preset, b0, b6, w80, f80n, lcn, vline, vact, r50;
  logic acc, oe_n;
  logic [5:0] row;
  logic [7:0] fcnt, pcnt, vcnt;
  tvt_pkg::tvt_counts_s obs;
  int bad_count = 0;
  int tests_run = 0;
  tvt_timing_top u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .sync_clear_in(sync_clear_in), .refresh_50hz_in(refresh_50hz_in),
    .test_observe_in(test_observe_in), .cmd_valid_in(cmd_valid_in),
    .dot_tick_out(), .dot_cycle_last_stage_n_out(last_n),
    .chargen_fetch_out(fetch), .serializer_preset_out(preset),
    .chargen_col_out(), .chargen_line_out(), .char_count_bit0_out(b0),
    .char_count_bit6_out(b6), .char_retrace_weight80_out(w80),
    .char_at_80_flag_n_out(f80n), .line_counter_clk_n_out(lcn),
    .video_line_out(vline), .video_active_out(vact), .row_cnt_out(row),
    .frame_end_out(), .refresh_50hz_out(r50), .cmd_accept_out(acc),
    .obs_counts_out(obs), .obs_oe_n_out(oe_n));
  tvt_crt_model u_crt (.mclk_in(mclk_in), .fetch_in(fetch),
    .preset_in(preset), .active_in(vact), .hsync_n_in(lcn),
    .fetch_cnt_out(fcnt), .preset_cnt_out(pcnt), .vis_cnt_out(vcnt));
  initial begin
    forever #20 mclk_in = ~mclk_in;
  end
  task automatic chk(input string n, input logic [7:0] e, s);
    tests_run++;
    if (s !== e) begin
      $display("[FAIL] %s exp %0h got %0h", n, e, s);
      bad_count++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : cyc
  task automatic t_dot;
    logic [3:0] e [7] = '{4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF, 4'h0};
    logic [3:0] pv;
    int k;
    for (k = 0; k < 100 && obs.dot_cnt !== 4'h0; k++) cyc(1);
    chk("last stage at 0", 8'h0, {7'h0, last_n});
    for (int i = 0; i < 7; i++) begin
      pv = obs.dot_cnt;
      for (k = 0; k < 20 && obs.dot_cnt === pv; k++) cyc(1);
      chk("dot", {4'h0, e[i]}, {4'h0, obs.dot_cnt});
    end
  endtask : t_dot
  // one whole line from just after a line pulse to just after the next
  task automatic t_line(input logic v, output logic [3:0] ln,
                        output logic [5:0] rw);
    logic [7:0] pv;
    int n, na, nc;
    cmd_valid_in = v;
    n = 0;
    na = 0;
    nc = 0;
    do begin
      pv = obs.char_cnt;
      cyc(1);
      n++;
      na += int'(acc === 1'b1);
      if (obs.char_cnt !== pv) begin
        nc++;
        if (nc == 1) begin
          ln = obs.line_cnt;
          rw = row;
          chk("vline", {7'h0, ln inside {[1:7]}}, {7'h0, vline});
        end
        if (pv == 8'h4E) chk("at 79", 8'h3, {5'h0, w80, b6, b0});
        if (pv == 8'h4F) begin
          chk("after 79", 8'hF0, obs.char_cnt);
          chk("at 80", 8'h6, {5'h0, w80, b6, b0});
          chk("flag 80", 8'h0, {7'h0, f80n});
        end
      end
    end while (lcn !== 1'b0 && n < 2000);
    cyc(1);
    chk("cells", 8'd96, nc[7:0]);
    chk("accepts", {7'h0, v}, na[7:0]);
    chk("period", 8'h1, {7'h0, n >= 1541 && n <= 1544});
    chk("fetches", 8'd96, fcnt);
    chk("presets", 8'd96, pcnt);
    chk("visible", (ln inside {[1:7]}) ? 8'd80 : 8'd0, vcnt);
  endtask : t_line
  task automatic t_lines;
    logic [3:0] ln, el;
    logic [5:0] rw, er;
    for (int k = 0; k < 2000 && lcn !== 1'b0; k++) cyc(1);
    cyc(1);
    for (int i = 0; i < 11; i++) begin
      if (i == 5) test_observe_in = 1'b0;
      t_line(i != 1, ln, rw);
      if (i > 0) begin
        el = (el == 4'h8) ? 4'h0 : el + 4'h1;
        er = er + {5'h0, el == 4'h0};
        chk("line", {4'h0, el}, {4'h0, ln});
        chk("row", {2'h0, er}, {2'h0, rw});
      end else begin
        el = ln;
        er = rw;
      end
    end
    chk("observe off", 8'h1, {7'h0, oe_n});
  endtask : t_lines
  task automatic t_clear;
    refresh_50hz_in = 1'b1;
    sync_clear_in = 1'b1;
    cyc(5);
    chk("clr dot", 8'hA, {4'h0, obs.dot_cnt});
    chk("clr char", 8'h0, obs.char_cnt);
    chk("clr line", 8'h0, {4'h0, obs.line_cnt});
    chk("clr row", 8'h0, {2'h0, obs.row_cnt});
    chk("strap 50", 8'h1, {7'h0, r50});
    sync_clear_in = 1'b0;
  endtask : t_clear
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    cyc(3);
    chk("rst dot", 8'hA, {4'h0, obs.dot_cnt});
    chk("rst flags", 8'h3, {6'h0, f80n, lcn});
    rst_n_in = 1'b1;
    cyc(5);
    chk("observe on", 8'h0, {7'h0, oe_n});
    t_dot();
    t_lines();
    t_clear();
    summarize();
  end
  // eleven lines of about 1543 cycles each, with ample margin
  initial begin
    #(40 * 60000);
    bad_count++;
    summarize();
  end
endmodule : tvt_timing_top_tb
